//--- rtl/spi_receive_status_flags.sv
// Receive-side status flags of the serial port, reached over APB
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module spi_receive_status_flags #(
    parameter int DW = spi_status_pkg::DATA_W
) (
    input  wire logic                              clk,
    input  wire logic                              reset,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [spi_status_pkg::ADDR_W-1:0] paddr,
    input  wire logic [spi_status_pkg::APB_W-1:0]  pwdata,
    output logic      [spi_status_pkg::APB_W-1:0]  prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    input  wire spi_status_pkg::rx_word_s          rxWord,
    output logic                                   irq
);
    // Byte address of a register index
    function automatic logic [spi_status_pkg::ADDR_W-1:0] regAddr(
        input logic [spi_status_pkg::ADDR_W-1:0] idx);
        regAddr = (spi_status_pkg::ADDR_W)'(idx * spi_status_pkg::IDX_TO_BYTE);
    endfunction

    logic                          access;
    logic                          wrAcc;
    logic                          rdAcc;
    logic                          hitStatus;
    logic                          hitData;
    logic                          hitMatch;
    logic                          hitIrqSts;
    logic                          hitIrqEn;
    logic                          hitIrqClr;
    logic                          mapped;
    logic [DW-1:0]                 rxBuf;
    logic [DW-1:0]                 statusByte;
    logic                          full_r;
    logic                          full_nxt;
    logic                          match_r;
    logic                          match_nxt;
    logic                          checkPend_r;
    logic                          checkPend_nxt;
    spi_status_pkg::arm_e          fullArm_r;
    spi_status_pkg::arm_e          fullArm_nxt;
    spi_status_pkg::arm_e          matchArm_r;
    spi_status_pkg::arm_e          matchArm_nxt;
    logic [DW-1:0]                 cmp_r;
    logic [DW-1:0]                 cmp_nxt;
    logic [spi_status_pkg::EV_W-1:0] evSts_r;
    logic [spi_status_pkg::EV_W-1:0] evSts_nxt;
    logic [spi_status_pkg::EV_W-1:0] evEn_r;
    logic [spi_status_pkg::EV_W-1:0] evEn_nxt;
    logic [spi_status_pkg::EV_W-1:0] evSet;
    logic                          fullClr;
    logic                          matchClr;
    logic                          matchSet;

    // APB decode; zero wait states, so pready is constant high
    assign access    = psel && penable;
    assign wrAcc     = access && pwrite;
    assign rdAcc     = access && !pwrite;
    assign hitStatus = (paddr == regAddr(spi_status_pkg::STATUS_IDX));
    assign hitData   = (paddr == regAddr(spi_status_pkg::DATA_IDX));
    assign hitMatch  = (paddr == regAddr(spi_status_pkg::MATCH_IDX));
    assign hitIrqSts = (paddr == regAddr(spi_status_pkg::IRQ_STS_IDX));
    assign hitIrqEn  = (paddr == regAddr(spi_status_pkg::IRQ_EN_IDX));
    assign hitIrqClr = (paddr == regAddr(spi_status_pkg::IRQ_CLR_IDX));
    assign mapped    = hitStatus | hitData | hitMatch | hitIrqSts | hitIrqEn | hitIrqClr;
    assign pready    = 1'b1;
    assign pslverr   = access && !mapped;

    // Receive data buffer, loaded on every completed transfer
    rx_hold_reg #(
        .W (DW)
    ) rx_hold_reg_inst (
        .clk     (clk),
        .reset   (reset),
        .load    (rxWord.done),
        .dataIn  (rxWord.data),
        .dataOut (rxBuf)
    );

    // Status byte image
    // low bits zero
    always_comb begin
        statusByte = '0;
        statusByte[spi_status_pkg::FULL_BIT]  = full_r;
        statusByte[spi_status_pkg::MATCH_BIT] = match_r;
        statusByte[spi_status_pkg::LOW_UNIMPL_W-1:0] = '0;
    end

    // Clear conditions; a sequence only counts once armed by a status read
    // read then data
    assign fullClr  = rdAcc && hitData && (fullArm_r == spi_status_pkg::ARM_READY);
    assign matchClr = wrAcc && hitStatus && pwdata[spi_status_pkg::MATCH_BIT]
                      && (matchArm_r == spi_status_pkg::ARM_READY);
    assign matchSet = checkPend_r && (rxBuf == cmp_r);

    // Flag next state; set wins over a clear in the same cycle
    always_comb begin
        full_nxt      = full_r;
        match_nxt     = match_r;
        checkPend_nxt = 1'b0;
        fullArm_nxt   = fullArm_r;
        matchArm_nxt  = matchArm_r;
        if (fullClr) begin
            full_nxt    = 1'b0;
            fullArm_nxt = spi_status_pkg::ARM_IDLE;
        end
        if (rdAcc && hitStatus && full_r) begin
            fullArm_nxt = spi_status_pkg::ARM_READY;
        end
        if (rxWord.done) begin
            full_nxt      = 1'b1;
            checkPend_nxt = 1'b1;
        end
        if (matchClr) begin
            match_nxt    = 1'b0;
            matchArm_nxt = spi_status_pkg::ARM_IDLE;
        end
        if (rdAcc && hitStatus && match_r) begin
            matchArm_nxt = spi_status_pkg::ARM_READY;
        end
        if (matchSet) begin
            match_nxt = 1'b1;
        end
    end

    // Software registers: compare value, event enable, event status
    // status write ignored
    always_comb begin
        cmp_nxt   = cmp_r;
        evEn_nxt  = evEn_r;
        evSet     = '0;
        evSet[spi_status_pkg::EV_RX_BIT]    = rxWord.done;
        evSet[spi_status_pkg::EV_MATCH_BIT] = matchSet;
        evSts_nxt = evSts_r;
        if (wrAcc && hitMatch) begin
            cmp_nxt = pwdata[DW-1:0];
        end
        if (wrAcc && hitIrqEn) begin
            evEn_nxt = pwdata[spi_status_pkg::EV_W-1:0];
        end
        if (wrAcc && hitIrqClr) begin
            evSts_nxt = evSts_r & ~pwdata[spi_status_pkg::EV_W-1:0];
        end
        evSts_nxt = evSts_nxt | evSet;
    end

    // Register stage
    // reset clears all
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            full_r      <= 1'b0;
            match_r     <= 1'b0;
            checkPend_r <= 1'b0;
            fullArm_r   <= spi_status_pkg::ARM_IDLE;
            matchArm_r  <= spi_status_pkg::ARM_IDLE;
            cmp_r       <= spi_status_pkg::MATCH_RESET;
            evSts_r     <= spi_status_pkg::EV_RESET;
            evEn_r      <= spi_status_pkg::EV_RESET;
        end else begin
            full_r      <= full_nxt;
            match_r     <= match_nxt;
            checkPend_r <= checkPend_nxt;
            fullArm_r   <= fullArm_nxt;
            matchArm_r  <= matchArm_nxt;
            cmp_r       <= cmp_nxt;
            evSts_r     <= evSts_nxt;
            evEn_r      <= evEn_nxt;
        end
    end

    // Read mux, combinational within the access phase; write-only clear reads zero
    always_comb begin
        prdata = '0;
        if (rdAcc) begin
            if (hitStatus) begin
                prdata[DW-1:0] = statusByte;
            end else if (hitData) begin
                prdata[DW-1:0] = rxBuf;
            end else if (hitMatch) begin
                prdata[DW-1:0] = cmp_r;
            end else if (hitIrqSts) begin
                prdata[spi_status_pkg::EV_W-1:0] = evSts_r;
            end else if (hitIrqEn) begin
                prdata[spi_status_pkg::EV_W-1:0] = evEn_r;
            end
        end
    end

    // Level interrupt while any enabled event is pending
    assign irq = |(evSts_r & evEn_r);

    property p_fullSet;
        @(posedge clk) disable iff (reset)
        rxWord.done |=> full_r;
    endproperty
    a_fullSet: assert property (p_fullSet) else $error("full not set after transfer");

    property p_fullHold;
        @(posedge clk) disable iff (reset)
        (full_r && !(rdAcc && hitData && fullArm_r == spi_status_pkg::ARM_READY))
            |=> full_r;
    endproperty
    a_fullHold: assert property (p_fullHold) else $error("full dropped without sequence");

    // armed data read clears; APB never gives two access cycles in a row
    property p_fullSeq;
        @(posedge clk) disable iff (reset)
        (rdAcc && hitData && fullArm_r == spi_status_pkg::ARM_READY && !rxWord.done)
            |=> !full_r;
    endproperty
    a_fullSeq: assert property (p_fullSeq) else $error("full not cleared by sequence");

    // low bits zero on status read
    property p_lowZero;
        @(posedge clk) disable iff (reset)
        (rdAcc && hitStatus) |-> (prdata[spi_status_pkg::LOW_UNIMPL_W-1:0] == '0);
    endproperty
    a_lowZero: assert property (p_lowZero) else $error("unimplemented bits nonzero");

    // match follows equal compare two cycles after completion
    property p_matchSet;
        @(posedge clk) disable iff (reset)
        (rxWord.done && rxWord.data == cmp_r) ##1 (rxBuf == cmp_r) |=> match_r;
    endproperty
    a_matchSet: assert property (p_matchSet) else $error("match not set");

    // match cleared by armed write of one
    property p_matchClr;
        @(posedge clk) disable iff (reset)
        (matchClr && !matchSet) |=> !match_r;
    endproperty
    a_matchClr: assert property (p_matchClr) else $error("match not cleared");

    // status write without arm keeps flags
    property p_noStore;
        @(posedge clk) disable iff (reset)
        (wrAcc && hitStatus && matchArm_r == spi_status_pkg::ARM_IDLE && match_r)
            |=> match_r;
    endproperty
    a_noStore: assert property (p_noStore) else $error("status write stored value");

    property p_rose;
        @(posedge clk) disable iff (reset)
        $rose(match_r) |-> $past(full_r);
    endproperty
    a_rose: assert property (p_rose) else $error("match without receive-full");

    property p_resetClr;
        @(posedge clk) $fell(reset) |-> (!full_r && !match_r);
    endproperty
    a_resetClr: assert property (p_resetClr) else $error("flags set after reset");

    property p_armDrop;
        @(posedge clk) $fell(reset)
            |-> (fullArm_r == spi_status_pkg::ARM_IDLE && matchArm_r == spi_status_pkg::ARM_IDLE);
    endproperty
    a_armDrop: assert property (p_armDrop) else $error("clear sequence armed after reset");

    // match holds until the armed write of one
    property p_matchHold;
        @(posedge clk) disable iff (reset)
        (match_r && !matchClr) |=> match_r;
    endproperty
    a_matchHold: assert property (p_matchHold) else $error("match dropped without clear");

    // no match without an equal buffer after completion
    property p_matchQuiet;
        @(posedge clk) disable iff (reset)
        (!match_r && !(checkPend_r && rxBuf == cmp_r)) |=> !match_r;
    endproperty
    a_matchQuiet: assert property (p_matchQuiet) else $error("match set without equal data");

    // status read shows the live flags
    property p_statusRead;
        @(posedge clk) disable iff (reset)
        (rdAcc && hitStatus) |-> (prdata[spi_status_pkg::FULL_BIT] == full_r
            && prdata[spi_status_pkg::MATCH_BIT] == match_r);
    endproperty
    a_statusRead: assert property (p_statusRead) else $error("status read flags wrong");
endmodule
`default_nettype wire

//--- rtl/spi_status_pkg.sv
// Shared constants and carriers for the receive status flag block
package spi_status_pkg;
    localparam int          DATA_W          = 8;
    localparam int          APB_W           = 32;
    localparam int          ADDR_W          = 12;
    // Printed offset 0x3 is not word aligned: kept as an index, byte address is four times it
    localparam logic [ADDR_W-1:0] STATUS_IDX  = 12'h003;
    localparam logic [ADDR_W-1:0] DATA_IDX    = 12'h005;
    localparam logic [ADDR_W-1:0] MATCH_IDX   = 12'h006;
    localparam logic [ADDR_W-1:0] IRQ_STS_IDX = 12'h008;
    localparam logic [ADDR_W-1:0] IRQ_EN_IDX  = 12'h009;
    localparam logic [ADDR_W-1:0] IRQ_CLR_IDX = 12'h00a;
    localparam logic [ADDR_W-1:0] IDX_TO_BYTE = 12'h004;
    localparam int          FULL_BIT        = 7;
    localparam int          MATCH_BIT       = 6;
    localparam int          LOW_UNIMPL_W    = 4;
    localparam int          EV_RX_BIT       = 0;
    localparam int          EV_MATCH_BIT    = 1;
    localparam int          EV_W            = 2;
    localparam logic [DATA_W-1:0] MATCH_RESET = 8'h00;
    localparam logic [EV_W-1:0]   EV_RESET    = 2'h0;

    // Received byte with its completion strobe
    typedef struct packed {
        logic              done;
        logic [DATA_W-1:0] data;
    } rx_word_s;

    // Clearing sequence state for one flag
    typedef enum logic [0:0] {ARM_IDLE, ARM_READY} arm_e;
endpackage

//--- rtl/rx_hold_reg.sv
// Receive data buffer register loaded on each completed transfer
`timescale 1ns/1ps
`default_nettype none
module rx_hold_reg #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         load,
    input  wire logic [W-1:0] dataIn,
    output logic      [W-1:0] dataOut
);
    logic [W-1:0] hold_r;
    logic [W-1:0] hold_nxt;

    // Keep the old byte unless a new transfer lands
    always_comb begin
        hold_nxt = load ? dataIn : hold_r;
    end

    // Register stage, read data comes out of a flop
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hold_r <= '0;
        end else begin
            hold_r <= hold_nxt;
        end
    end

    assign dataOut = hold_r;
endmodule
`default_nettype wire

//--- testbench/serial_partner.sv
// Behavioural far-side serial partner that delivers received bytes
`timescale 1ns/1ps
`default_nettype none
module serial_partner (
    input  wire logic                  clk,
    output var spi_status_pkg::rx_word_s rxWord
);
    // Idle data starts at zero, then shows the inverse of the last byte so stale values are never trusted
    initial begin
        rxWord = '0;
    end

    // One completion pulse per byte; hold keeps done high for a back-to-back byte
    task automatic send(input logic [7:0] b, input bit hold);
        @(posedge clk);
        rxWord.done <= 1'b1;
        rxWord.data <= b;
        if (!hold) begin
            @(posedge clk);
            rxWord.done <= 1'b0;
            rxWord.data <= ~b;
        end
    endtask
endmodule
`default_nettype wire

//--- testbench/tb_spi_receive_status_flags.sv
// Self-checking bench for the receive status flags over APB
`timescale 1ns/1ps
`default_nettype none
module tb_spi_receive_status_flags;
    logic                              clk = 1'b0;
    logic                              reset = 1'b1;
    logic                              psel = 1'b0;
    logic                              penable = 1'b0;
    logic                              pwrite = 1'b0;
    logic [spi_status_pkg::ADDR_W-1:0] paddr = '0;
    logic [spi_status_pkg::APB_W-1:0]  pwdata = '0;
    logic [spi_status_pkg::APB_W-1:0]  prdata;
    logic                              pready;
    logic                              pslverr;
    logic                              irq;
    spi_status_pkg::rx_word_s          rxWord;
    int                                errors = 0;
    int                                cmp_count = 0;
    int                                cycles = 0;
    logic [31:0]                       rdVal;
    logic                              errVal;

    spi_receive_status_flags spi_receive_status_flags_inst (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxWord(rxWord), .irq(irq)
    );
    serial_partner serial_partner_inst (.clk(clk), .rxWord(rxWord));

    // 200 MHz clock
    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            give_verdict();
        end
    end

    // One APB transfer; outputs are read in the active region of the sampling edge
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx[9:0], 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // Wait for the answer; only the hang guard ends a stuck wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        logic e;
        apb(1'b1, idx, wd, d, e);
    endtask

    task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        logic e;
        apb(1'b0, idx, 32'h0, d, e);
        check(d, exp);
    endtask

    task automatic pulse_reset();
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        // Reset state
        rd_chk(spi_status_pkg::STATUS_IDX, 32'h0);
        check({31'h0, irq}, 32'h0);
        $display("Test reset state done");
        // Full flag needs status read before data read
        serial_partner_inst.send(8'h5a, 1'b0);
        rd_chk(spi_status_pkg::DATA_IDX, 32'h5a);
        rd_chk(spi_status_pkg::STATUS_IDX, 32'h80);
        // Reset must drop the flag and the arm left by the read above
        pulse_reset();
        rd_chk(spi_status_pkg::STATUS_IDX, 32'h0);
        serial_partner_inst.send(8'ha5, 1'b0);
        rd_chk(spi_status_pkg::DATA_IDX, 32'ha5);
        rd_chk(spi_status_pkg::STATUS_IDX, 32'h80);
        wr(spi_status_pkg::STATUS_IDX, 32'hff);
        rd_chk(spi_status_pkg::STATUS_IDX, 32'h80);
        rd_chk(spi_status_pkg::DATA_IDX, 32'ha5);
        rd_chk(spi_status_pkg::STATUS_IDX, 32'h0);
        $display("Test full flag done");
        // Match flag and its write-one clear; events masked first
        pulse_reset();
        wr(spi_status_pkg::MATCH_IDX, 32'h3c);
        serial_partner_inst.send(8'h3c, 1'b0);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        wr(spi_status_pkg::STATUS_IDX, 32'h40);
        rd_chk(spi_status_pkg::STATUS_IDX, 32'hc0);
        wr(spi_status_pkg::STATUS_IDX, 32'hbf);
        rd_chk(spi_status_pkg::STATUS_IDX, 32'hc0);
        wr(spi_status_pkg::IRQ_EN_IDX, 32'h3);
        rd_chk(spi_status_pkg::IRQ_STS_IDX, 32'h3);
        check({31'h0, irq}, 32'h1);
        wr(spi_status_pkg::STATUS_IDX, 32'h40);
        rd_chk(spi_status_pkg::STATUS_IDX, 32'h80);
        wr(spi_status_pkg::IRQ_CLR_IDX, 32'h3);
        rd_chk(spi_status_pkg::IRQ_STS_IDX, 32'h0);
        check({31'h0, irq}, 32'h0);
        $display("Test match flag done");
        // Back-to-back bytes: the first equals the compare value, so match sets
        serial_partner_inst.send(8'h3c, 1'b1);
        serial_partner_inst.send(8'h11, 1'b0);
        rd_chk(spi_status_pkg::STATUS_IDX, 32'hc0);
        rd_chk(spi_status_pkg::DATA_IDX, 32'h11);
        rd_chk(spi_status_pkg::IRQ_STS_IDX, 32'h3);
        check({31'h0, irq}, 32'h1);
        $display("Test back to back done");
        // Unmapped address is refused
        apb(1'b0, 12'h0ff, 32'h0, rdVal, errVal);
        check(rdVal, 32'h0);
        check({31'h0, errVal}, 32'h1);
        $display("Test unmapped done");
        give_verdict();
    end
endmodule
`default_nettype wire
